/* pkg/cacs_pkg.sv */
// Shared constants, types and helpers for the card activation and class select link
package cacs_pkg;
   // ==============================
   // Card clock
   localparam int REF_HZ = 10_000_000;
   localparam int CLK_MAX_HZ = 5_000_000;
   localparam int CLK_MIN_HZ = 1_000_000;
   localparam int CLK_HALF_MIN = REF_HZ / (2 * CLK_MAX_HZ);
   localparam int CLK_HALF_MAX = REF_HZ / (2 * CLK_MIN_HZ);
   localparam int DUTY_MIN_PCT = 40;
   localparam int DUTY_MAX_PCT = 60;

   // ==============================
   // Timing in card clock periods, and the corrupted-answer limit
   localparam int ETU_CLKS_DEF = 372;
   localparam int ATR_DELAY_DEF = 400;
   localparam int RST_LOW_DEF = 400;
   localparam int OFF_CLKS_DEF = 400;
   localparam int ATR_WAIT_DEF = 40000;
   localparam logic [1:0] CORRUPT_LIMIT = 2'h3;

   // ==============================
   // Supply classes, one-hot as in the indicator byte
   typedef logic [2:0] cacs_class_t;
   localparam cacs_class_t CLS_NONE = 3'h0;
   localparam cacs_class_t CLS_A = 3'h1;
   localparam cacs_class_t CLS_B = 3'h2;
   localparam cacs_class_t CLS_C = 3'h4;

   // ==============================
   // Answer-to-reset framing
   localparam logic [7:0] TS_DIRECT = 8'h3b;
   localparam logic [7:0] ATR_T0 = 8'h80;
   localparam logic [7:0] ATR_TD1 = 8'h80;
   localparam logic [7:0] ATR_TD2 = 8'h1f;
   localparam logic [3:0] PROTO_T0 = 4'h0;
   localparam logic [3:0] PROTO_GLOBAL = 4'hf;
   localparam logic [3:0] BIT_PARITY = 4'h9;
   localparam logic [3:0] BIT_LAST = 4'hb;
   localparam logic [2:0] ATR_LAST = 3'h5;

   // Set bits form one unbroken run
   function automatic logic cacs_adjacent(input logic [4:0] ind);
      logic [5:0] v;
      logic [5:0] low;
      v = {1'b0, ind};
      low = v & (~v + 6'h01);
      return (ind != 5'h00) && (((v + low) & v) == 6'h00);
   endfunction

   // Lowest voltage first: C, then B, then A
   function automatic cacs_class_t cacs_lowest(input cacs_class_t m);
      if (m[2]) begin
         return CLS_C;
      end
      if (m[1]) begin
         return CLS_B;
      end
      return m[0] ? CLS_A : CLS_NONE;
   endfunction
endpackage

/* pkg/cacs_link_if.sv */
// Card contacts between terminal and card: clock, reset, supply class and open-drain I/O
interface cacs_link_if;
   logic card_clk;
   logic card_rst_n;
   cacs_pkg::cacs_class_t vcc_sel;
   logic card_io_o;
   logic card_io_oe;
   logic io_line;

   // ==============================
   // Pull-up on I/O; only the card pulls it low
   assign io_line = !(card_io_oe && !card_io_o);

   modport term (output card_clk, output card_rst_n, output vcc_sel, input io_line);
   modport card (input card_clk, input card_rst_n, input vcc_sel, output card_io_o, output card_io_oe);
endinterface

/* design/cacs_card.sv */
// Card end: sends its answer-to-reset with class indicator, clocked by the card clock
module cacs_card #(
   parameter int ETU_CLKS = cacs_pkg::ETU_CLKS_DEF,
   parameter int ATR_DELAY = cacs_pkg::ATR_DELAY_DEF
) (
   input wire logic sys_rst, // Power-on reset, card clock domain
   input wire logic [4:0] class_ind, // Classes this card supports
   input wire logic mute, // Card stays silent
   input wire logic corrupt, // Flip parity of every byte
   output logic atr_sent_ff, // Answer sent since reset
   output logic ind_ok_ff, // Given indicator is adjacent
   cacs_link_if.card link // Card contacts
);
   import cacs_pkg::*;

   localparam logic [15:0] ETU_LAST = 16'(ETU_CLKS - 1);
   localparam logic [15:0] DELAY_LAST = 16'(ATR_DELAY - 1);

   typedef enum logic [1:0] {
      CD_IDLE = 2'b00,
      CD_WAIT = 2'b01,
      CD_SEND = 2'b11,
      CD_DONE = 2'b10
   } cacs_cstate_e;

   cacs_cstate_e state_ff;
   logic rst_meta_ff;
   logic rst_sync_ff;
   cacs_class_t vcc_meta_ff;
   cacs_class_t vcc_sync_ff;
   logic active;
   logic [15:0] cnt_ff;
   logic [3:0] bit_ff;
   logic [2:0] idx_ff;
   logic corrupt_ff;
   logic oe_ff;
   logic [4:0] ind_tx;
   logic [7:0] ta3;
   logic [7:0] tck;
   logic [7:0] tx_byte;
   logic tx_bit;
   logic [6:0] cfg_meta_ff;
   logic [6:0] cfg_sync_ff;
   logic [4:0] ind_s;
   logic mute_s;
   logic corrupt_s;

   // ==============================
   // Contact synchronisers; the card has no clock but the one on its contact
   always_ff @(posedge link.card_clk) begin // RULE3
      rst_meta_ff <= link.card_rst_n;
      rst_sync_ff <= rst_meta_ff;
      vcc_meta_ff <= link.vcc_sel;
      vcc_sync_ff <= vcc_meta_ff;
      cfg_meta_ff <= {class_ind, mute, corrupt};
      cfg_sync_ff <= cfg_meta_ff;
   end

   // Straps come from outside the card clock; assumed steady while an answer is built
   assign {ind_s, mute_s, corrupt_s} = cfg_sync_ff;

   assign active = rst_sync_ff && (vcc_sync_ff != CLS_NONE);

   // ==============================
   // Answer content; a broken run is cut to its lowest indicator bit
   assign ind_tx = cacs_adjacent(ind_s) ? ind_s : (ind_s & (~ind_s + 5'h01)); // RULE12 RULE13
   assign ta3 = {3'h0, ind_tx}; // RULE11
   assign tck = ATR_T0 ^ ATR_TD1 ^ ATR_TD2 ^ ta3;

   always_comb begin
      unique case (idx_ff)
         3'h0: tx_byte = TS_DIRECT;
         3'h1: tx_byte = ATR_T0;
         3'h2: tx_byte = ATR_TD1;
         3'h3: tx_byte = ATR_TD2; // RULE16
         3'h4: tx_byte = ta3;
         default: tx_byte = tck;
      endcase
   end

   always_comb begin
      if (bit_ff == 4'h0) begin
         tx_bit = 1'b0;
      end else if (bit_ff < BIT_PARITY) begin
         tx_bit = tx_byte[3'(bit_ff - 4'h1)];
      end else if (bit_ff == BIT_PARITY) begin
         tx_bit = (^tx_byte) ^ corrupt_ff;
      end else begin
         tx_bit = 1'b1;
      end
   end

   // ==============================
   // Sequence: wait after reset release, send once, then stay silent
   always_ff @(posedge link.card_clk) begin
      if (sys_rst || !active) begin
         state_ff <= CD_IDLE;
         cnt_ff <= 16'h0000;
         bit_ff <= 4'h0;
         idx_ff <= 3'h0;
         corrupt_ff <= 1'b0;
         oe_ff <= 1'b0;
         atr_sent_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            CD_IDLE: begin
               cnt_ff <= 16'h0000;
               if (!mute_s) begin
                  state_ff <= CD_WAIT;
               end
            end
            CD_WAIT: begin
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff == DELAY_LAST) begin
                  state_ff <= CD_SEND; // RULE14
                  cnt_ff <= 16'h0000;
                  corrupt_ff <= corrupt_s;
               end
            end
            CD_SEND: begin
               oe_ff <= !tx_bit;
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff == ETU_LAST) begin
                  cnt_ff <= 16'h0000;
                  bit_ff <= bit_ff + 4'h1;
                  if (bit_ff == BIT_LAST) begin
                     bit_ff <= 4'h0;
                     idx_ff <= idx_ff + 3'h1;
                     if (idx_ff == ATR_LAST) begin
                        state_ff <= CD_DONE;
                        atr_sent_ff <= 1'b1;
                     end
                  end
               end
            end
            CD_DONE: begin
               oe_ff <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link.card_clk) begin
      if (sys_rst) begin
         ind_ok_ff <= 1'b0;
      end else begin
         ind_ok_ff <= cacs_adjacent(ind_s);
      end
   end

   assign link.card_io_oe = oe_ff;
   assign link.card_io_o = 1'b0;
endmodule

/* design/cacs_term.sv */
// Terminal end: card clock, class selection, activation retries and answer-to-reset parsing
// Behaviour
// RULE1 - Terminal drives card clock, 1 to 5 MHz
// RULE2 - Clock high time 40 to 60 percent
// RULE3 - Card runs only from the supplied clock
// RULE4 - Class selection finishes before any other activity
// RULE5 - First power-up at lowest offered class
// RULE6 - No answer: power down, try next class
// RULE7 - Unsupported class: restart in a listed class
// RULE8 - No common class: never send commands
// RULE9 - Corrupted answer: reset three times, same class
// RULE10 - After three corrupted: only next higher class
// RULE11 - Card lists classes in late TA byte
// RULE12 - Indicator bits 1, 2, 3 mean A, B, C
// RULE13 - Several indicated classes must be adjacent
// RULE14 - Answer is first thing sent after reset
// RULE15 - Accept other protocols, history, check byte
// RULE16 - Card always sends global interface parameters
// RULE17 - Deselect application demanding too much power
// RULE18 - Corrupt count cleared on class change, success
module cacs_term #(
   parameter int CLK_HALF = cacs_pkg::CLK_HALF_MIN,
   parameter int ETU_CLKS = cacs_pkg::ETU_CLKS_DEF,
   parameter int RST_LOW = cacs_pkg::RST_LOW_DEF,
   parameter int OFF_CLKS = cacs_pkg::OFF_CLKS_DEF,
   parameter int ATR_WAIT = cacs_pkg::ATR_WAIT_DEF
) (
   input wire logic ref_clk, // System clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic start, // Begin activation
   input wire cacs_pkg::cacs_class_t term_classes, // Classes the terminal offers
   input wire logic [7:0] app_pwr, // Power the application asks for
   input wire logic [7:0] pwr_max, // Power the terminal announced
   output cacs_pkg::cacs_class_t class_ff, // Class in use
   output logic busy_ff, // Activation in progress
   output logic ready_ff, // Card usable, commands allowed
   output logic reject_ff, // Card rejected
   output logic no_common_ff, // No class in common
   output logic [1:0] corrupt_cnt_ff, // Consecutive corrupted answers
   output logic [4:0] ind_ff, // Received class indicator
   output logic deselect_ff, // Application must be deselected
   cacs_link_if.term link // Card contacts
);
   import cacs_pkg::*;

   localparam int CYC = 2 * CLK_HALF;
   localparam logic [7:0] DIV_LAST = 8'(CLK_HALF - 1);
   localparam logic [19:0] ETU_CYC = 20'(ETU_CLKS * CYC);
   localparam logic [19:0] HALF_ETU = 20'(ETU_CLKS * CLK_HALF);
   localparam logic [19:0] RST_CYC = 20'(RST_LOW * CYC);
   localparam logic [19:0] OFF_CYC = 20'(OFF_CLKS * CYC);
   localparam logic [19:0] WAIT_CYC = 20'(ATR_WAIT * CYC);

   typedef enum logic [2:0] {
      T_IDLE = 3'b000,
      T_OFF = 3'b001,
      T_RSTLO = 3'b011,
      T_ATR = 3'b010,
      T_EVAL = 3'b110,
      T_READY = 3'b111,
      T_FAIL = 3'b101
   } cacs_tstate_e;

   cacs_tstate_e state_ff;
   cacs_class_t vcc_ff;
   cacs_class_t up_class;
   logic rst_n_ff;
   logic clk_ff;
   logic [7:0] div_ff;
   logic [19:0] tmr_ff;
   logic io_meta_ff;
   logic io_sync_ff;
   logic io_prev_ff;
   logic rx_busy_ff;
   logic [19:0] rx_cnt_ff;
   logic [3:0] rx_bit_ff;
   logic [8:0] rx_sh_ff;
   logic byte_vld_ff;
   logic [5:0] pidx_ff;
   logic [3:0] mask_ff;
   logic [3:0] hist_ff;
   logic [3:0] ti_ff;
   logic tck_ff;
   logic taind_ff;
   logic indf_ff;
   logic [7:0] xor_ff;
   logic done_ff;
   logic bad_ff;
   logic got_ff;
   logic good_ff;
   logic [3:0] nxt_mask;
   logic [3:0] nxt_hist;
   logic [3:0] nxt_ti;
   logic nxt_tck;
   logic nxt_taind;
   logic nxt_indf;
   logic [4:0] nxt_ind;
   logic p_bad;
   logic p_fin;
   logic [7:0] b;
   logic ans_ok;
   logic warm_retry;
   logic pwr_cut;

   // ==============================
   // Card clock: even divider, so high time is exactly half; stopped while unpowered
   // It stops on the very edge that drops the supply, never one clock after it
   always_ff @(posedge ref_clk) begin // RULE1 RULE2
      if (sys_rst || vcc_ff == CLS_NONE || pwr_cut) begin
         div_ff <= 8'h00;
         clk_ff <= 1'b0;
      end else if (div_ff == DIV_LAST) begin
         div_ff <= 8'h00;
         clk_ff <= ~clk_ff;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   // ==============================
   // Receiver: I/O synchronised, sampled mid-bit, 8 data plus even parity
   always_ff @(posedge ref_clk) begin
      io_meta_ff <= link.io_line;
      io_sync_ff <= io_meta_ff;
      io_prev_ff <= io_sync_ff;
   end

   always_ff @(posedge ref_clk) begin
      byte_vld_ff <= 1'b0;
      if (sys_rst || state_ff != T_ATR) begin
         rx_busy_ff <= 1'b0;
         rx_cnt_ff <= 20'h00000;
         rx_bit_ff <= 4'h0;
         rx_sh_ff <= 9'h000;
      end else if (!rx_busy_ff) begin
         if (io_prev_ff && !io_sync_ff) begin
            rx_busy_ff <= 1'b1;
            rx_cnt_ff <= HALF_ETU;
            rx_bit_ff <= 4'h0;
         end
      end else if (rx_cnt_ff != 20'h00000) begin
         rx_cnt_ff <= rx_cnt_ff - 20'h00001;
      end else begin
         rx_cnt_ff <= ETU_CYC - 20'h00001;
         if (rx_bit_ff == 4'h0 && io_sync_ff) begin
            rx_busy_ff <= 1'b0;
         end else begin
            rx_sh_ff <= {io_sync_ff, rx_sh_ff[8:1]};
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff == BIT_PARITY) begin
               rx_busy_ff <= 1'b0;
               byte_vld_ff <= 1'b1;
            end
         end
      end
   end

   // ==============================
   // Parser walks any interface bytes, history and check byte it is told of
   assign b = rx_sh_ff[7:0];

   always_comb begin // RULE15
      nxt_mask = mask_ff;
      nxt_hist = hist_ff;
      nxt_ti = ti_ff;
      nxt_tck = tck_ff;
      nxt_taind = taind_ff;
      nxt_indf = indf_ff;
      nxt_ind = ind_ff;
      p_bad = ^rx_sh_ff;
      if (pidx_ff == 6'h00) begin
         p_bad = p_bad || (b != TS_DIRECT);
      end else if (pidx_ff == 6'h01) begin
         nxt_mask = b[7:4];
         nxt_hist = b[3:0];
         nxt_ti = 4'h1;
      end else if (mask_ff[0]) begin
         nxt_mask[0] = 1'b0;
         if (taind_ff) begin // RULE11 RULE16
            nxt_ind = b[4:0];
            nxt_indf = 1'b1;
            nxt_taind = 1'b0;
         end
      end else if (mask_ff[1]) begin
         nxt_mask[1] = 1'b0;
      end else if (mask_ff[2]) begin
         nxt_mask[2] = 1'b0;
      end else if (mask_ff[3]) begin
         nxt_mask = b[7:4];
         nxt_ti = ti_ff + 4'h1;
         nxt_tck = tck_ff || (b[3:0] != PROTO_T0);
         nxt_taind = (b[3:0] == PROTO_GLOBAL) && (ti_ff >= 4'h2) && !indf_ff && b[4];
      end else if (hist_ff != 4'h0) begin
         nxt_hist = hist_ff - 4'h1;
      end else begin
         nxt_tck = 1'b0;
         p_bad = p_bad || ((xor_ff ^ b) != 8'h00);
      end
      p_fin = (pidx_ff != 6'h00) && (nxt_mask == 4'h0) && (nxt_hist == 4'h0) && !nxt_tck;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || state_ff == T_RSTLO) begin
         pidx_ff <= 6'h00;
         mask_ff <= 4'h0;
         hist_ff <= 4'h0;
         ti_ff <= 4'h0;
         tck_ff <= 1'b0;
         taind_ff <= 1'b0;
         indf_ff <= 1'b0;
         ind_ff <= 5'h00;
         xor_ff <= 8'h00;
         done_ff <= 1'b0;
         bad_ff <= 1'b0;
      end else if (byte_vld_ff && state_ff == T_ATR && !done_ff) begin
         pidx_ff <= pidx_ff + 6'h01;
         mask_ff <= nxt_mask;
         hist_ff <= nxt_hist;
         ti_ff <= nxt_ti;
         tck_ff <= nxt_tck;
         taind_ff <= nxt_taind;
         indf_ff <= nxt_indf;
         ind_ff <= nxt_ind;
         xor_ff <= (pidx_ff == 6'h00) ? 8'h00 : (xor_ff ^ b);
         done_ff <= p_fin || p_bad;
         bad_ff <= p_bad;
      end
   end

   // ==============================
   // Activation sequencer
   assign up_class = class_ff >> 1;
   assign ans_ok = good_ff && cacs_adjacent(ind_ff);
   assign warm_retry = !ans_ok && got_ff && (corrupt_cnt_ff < CORRUPT_LIMIT - 2'h1);
   // Every path that drops the supply, seen one edge ahead for the clock divider
   assign pwr_cut = ((state_ff == T_IDLE || state_ff == T_READY || state_ff == T_FAIL) && start)
                  || (state_ff == T_EVAL && !warm_retry && !(ans_ok && (ind_ff[2:0] & class_ff) != CLS_NONE));

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_ff <= T_IDLE;
         class_ff <= CLS_NONE;
         vcc_ff <= CLS_NONE;
         rst_n_ff <= 1'b0;
         tmr_ff <= 20'h00000;
         busy_ff <= 1'b0;
         ready_ff <= 1'b0;
         reject_ff <= 1'b0;
         no_common_ff <= 1'b0;
         corrupt_cnt_ff <= 2'h0;
         got_ff <= 1'b0;
         good_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            T_IDLE, T_READY, T_FAIL: begin
               if (start) begin
                  class_ff <= cacs_lowest(term_classes); // RULE5
                  corrupt_cnt_ff <= 2'h0;
                  ready_ff <= 1'b0;
                  no_common_ff <= 1'b0;
                  reject_ff <= term_classes == CLS_NONE;
                  busy_ff <= term_classes != CLS_NONE;
                  state_ff <= (term_classes == CLS_NONE) ? T_FAIL : T_OFF;
                  vcc_ff <= CLS_NONE;
                  rst_n_ff <= 1'b0;
                  tmr_ff <= 20'h00000;
               end
            end
            T_OFF: begin
               tmr_ff <= tmr_ff + 20'h00001;
               if (tmr_ff == OFF_CYC) begin
                  vcc_ff <= class_ff;
                  tmr_ff <= 20'h00000;
                  state_ff <= T_RSTLO;
               end
            end
            T_RSTLO: begin
               tmr_ff <= tmr_ff + 20'h00001;
               if (tmr_ff == RST_CYC) begin
                  rst_n_ff <= 1'b1;
                  tmr_ff <= 20'h00000;
                  state_ff <= T_ATR;
               end
            end
            T_ATR: begin
               tmr_ff <= (rx_busy_ff || byte_vld_ff) ? 20'h00000 : tmr_ff + 20'h00001;
               if (done_ff || tmr_ff == WAIT_CYC) begin
                  got_ff <= done_ff || (pidx_ff != 6'h00);
                  good_ff <= done_ff && !bad_ff;
                  state_ff <= T_EVAL;
               end
            end
            T_EVAL: begin
               tmr_ff <= 20'h00000;
               rst_n_ff <= 1'b0;
               if (ans_ok) begin // RULE13
                  corrupt_cnt_ff <= 2'h0; // RULE18
                  if ((ind_ff[2:0] & class_ff) != CLS_NONE) begin // RULE4 RULE12
                     rst_n_ff <= 1'b1;
                     ready_ff <= 1'b1;
                     busy_ff <= 1'b0;
                     state_ff <= T_READY;
                  end else if ((ind_ff[2:0] & term_classes) != CLS_NONE) begin // RULE7
                     class_ff <= cacs_lowest(ind_ff[2:0] & term_classes);
                     vcc_ff <= CLS_NONE;
                     state_ff <= T_OFF;
                  end else begin // RULE8
                     no_common_ff <= 1'b1;
                     busy_ff <= 1'b0;
                     vcc_ff <= CLS_NONE;
                     state_ff <= T_FAIL;
                  end
               end else if (warm_retry) begin // RULE9
                  corrupt_cnt_ff <= corrupt_cnt_ff + 2'h1;
                  state_ff <= T_RSTLO;
               end else if ((up_class & term_classes) != CLS_NONE) begin // RULE6 RULE10
                  class_ff <= up_class;
                  corrupt_cnt_ff <= 2'h0; // RULE18
                  vcc_ff <= CLS_NONE;
                  state_ff <= T_OFF;
               end else begin
                  corrupt_cnt_ff <= got_ff ? CORRUPT_LIMIT : 2'h0;
                  reject_ff <= 1'b1;
                  busy_ff <= 1'b0;
                  vcc_ff <= CLS_NONE;
                  state_ff <= T_FAIL;
               end
            end
            default: begin
               state_ff <= T_IDLE;
               vcc_ff <= CLS_NONE;
               rst_n_ff <= 1'b0;
            end
         endcase
      end
   end

   // Application power check only matters once the card is in use
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         deselect_ff <= 1'b0;
      end else begin
         deselect_ff <= ready_ff && (app_pwr > pwr_max); // RULE17
      end
   end

   assign link.card_clk = clk_ff;
   assign link.card_rst_n = rst_n_ff;
   assign link.vcc_sel = vcc_ff;
endmodule

/* sim/cacs_link_sva.sv */
// Assertions on the card contacts between terminal and card
module cacs_link_sva #(
   parameter int CLK_HALF = 1
) (
   input wire logic ref_clk, // System clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic card_clk, // Card clock
   input wire logic card_rst_n, // Card reset
   input wire cacs_pkg::cacs_class_t vcc_sel, // Supply class
   input wire logic card_io_o, // Card I/O value
   input wire logic card_io_oe, // Card I/O pull-down
   input wire logic io_line // Resolved I/O
);
   import cacs_pkg::*;
   // One cycle of slack on the low phase; the first one after power-up is no longer than the rest
   localparam int LO_MAX = CLK_HALF + 1;
   logic [7:0] hi_cnt_ff;
   logic [7:0] lo_cnt_ff;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // ==============================
   // Clock phase counters
   always_ff @(posedge ref_clk) begin
      hi_cnt_ff <= card_clk ? hi_cnt_ff + 8'h01 : 8'h00;
   end
   always_ff @(posedge ref_clk) begin
      lo_cnt_ff <= (vcc_sel != CLS_NONE && !card_clk) ? lo_cnt_ff + 8'h01 : 8'h00;
   end

   // ==============================
   // Contact rules
   a_clk_unpowered: assert property (vcc_sel == CLS_NONE |-> !card_clk)
      else $error("card clock runs without supply");
   a_clk_low_bound: assert property (vcc_sel != CLS_NONE |-> lo_cnt_ff <= LO_MAX)
      else $error("card clock stalled while powered");
   a_clk_high_time: assert property ($fell(card_clk) && vcc_sel != CLS_NONE |-> hi_cnt_ff == CLK_HALF)
      else $error("card clock high phase wrong");
   a_vcc_one_class: assert property ($onehot0(vcc_sel))
      else $error("more than one supply class");
   a_rst_unpowered: assert property (vcc_sel == CLS_NONE |-> !card_rst_n)
      else $error("card reset released without supply");
   a_rst_release_pwr: assert property ($rose(card_rst_n) |-> vcc_sel != CLS_NONE && $stable(vcc_sel))
      else $error("reset released during class switch");
   a_class_via_off: assert property ($changed(vcc_sel) && $past(vcc_sel) != CLS_NONE |-> vcc_sel == CLS_NONE)
      else $error("class changed without power-down");
   a_atr_quiet: assert property ($rose(card_rst_n) |-> !card_io_oe [*8])
      else $error("card talks right at reset release");
   a_io_active: assert property ($rose(card_io_oe) |-> card_rst_n && vcc_sel != CLS_NONE)
      else $error("card drives I/O while inactive");
   a_io_free_release: assert property ($rose(card_rst_n) |-> io_line)
      else $error("I/O held low at reset release");
endmodule

/* sim/card_activation_class_select_tb.sv */
// Self-checking bench: terminal and card joined over the card contacts
module card_activation_class_select_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import cacs_pkg::*;
   localparam int HALF = 1;
   logic ref_clk;
   logic sys_rst;
   logic start;
   cacs_class_t term_classes;
   logic [7:0] app_pwr;
   logic [7:0] pwr_max;
   logic [4:0] class_ind;
   logic mute;
   logic corrupt;
   cacs_class_t cls;
   logic busy, ready, reject, no_common, desel, atr_sent, ind_ok;
   logic [1:0] cnt;
   logic [4:0] ind;
   int n_fail = 0;
   int cmp_count = 0;
   int n_rst;
   cacs_class_t seen_q[$];

   cacs_link_if link_i ();
   cacs_term #(.CLK_HALF(HALF), .ETU_CLKS(16), .RST_LOW(20), .OFF_CLKS(10), .ATR_WAIT(2000)) cacs_term_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .start(start), .term_classes(term_classes), .app_pwr(app_pwr),
      .pwr_max(pwr_max), .class_ff(cls), .busy_ff(busy), .ready_ff(ready), .reject_ff(reject),
      .no_common_ff(no_common), .corrupt_cnt_ff(cnt), .ind_ff(ind), .deselect_ff(desel), .link(link_i.term));
   cacs_card #(.ETU_CLKS(16)) cacs_card_i (
      .sys_rst(sys_rst), .class_ind(class_ind), .mute(mute), .corrupt(corrupt), .atr_sent_ff(atr_sent),
      .ind_ok_ff(ind_ok), .link(link_i.card));
   cacs_link_sva #(.CLK_HALF(HALF)) cacs_link_sva_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .card_clk(link_i.card_clk), .card_rst_n(link_i.card_rst_n),
      .vcc_sel(link_i.vcc_sel), .card_io_o(link_i.card_io_o), .card_io_oe(link_i.card_io_oe),
      .io_line(link_i.io_line));

   // ==============================
   // Clock and link monitors
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge link_i.card_rst_n) n_rst++;
   always @(link_i.vcc_sel) begin
      if (link_i.vcc_sel != CLS_NONE) seen_q.push_back(link_i.vcc_sel);
   end

   // ==============================
   // Tasks
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Whole activation; returns once the terminal is no longer busy
   task automatic activate(input cacs_class_t offer, input logic [4:0] ci, input logic m, input logic c);
      int i;
      tick(1);
      term_classes = offer;
      class_ind = ci;
      mute = m;
      corrupt = c;
      n_rst = 0;
      seen_q.delete();
      start = 1'b1;
      tick(1);
      start = 1'b0;
      i = 0;
      while (busy !== 1'b0 && i < 30000) begin
         tick(1);
         i++;
      end
      if (i == 30000) n_fail++;
   endtask

   task automatic give_verdict();
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge ref_clk);
      n_fail++;
      give_verdict();
   end

   // ==============================
   // Scenarios
   initial begin
      sys_rst = 1'b1;
      start = 1'b0;
      term_classes = CLS_NONE;
      app_pwr = 8'h20;
      pwr_max = 8'h10;
      class_ind = 5'h00;
      mute = 1'b0;
      corrupt = 1'b0;
      tick(8);
      sys_rst = 1'b0;
      activate(3'h7, 5'h06, 1'b0, 1'b0);
      check(ready, 1'b1);
      check(cls, CLS_C);
      check(8'(seen_q.size()), 8'h01);
      check(ind, 5'h06);
      check(ind_ok, 1'b1);
      check(cnt, 2'h0);
      tick(2);
      check(desel, 1'b1);
      app_pwr = 8'h10;
      tick(2);
      check(desel, 1'b0);
      pwr_max = 8'h0f;
      tick(2);
      check(desel, 1'b1);
      tick(120);
      check(atr_sent, 1'b1);
      activate(3'h7, 5'h03, 1'b0, 1'b0);
      check(ready, 1'b1);
      check(cls, CLS_B);
      check(seen_q[0], CLS_C);
      activate(3'h3, 5'h04, 1'b0, 1'b0);
      check(no_common, 1'b1);
      check(ready, 1'b0);
      check(link_i.vcc_sel, CLS_NONE);
      activate(3'h6, 5'h06, 1'b1, 1'b0);
      check(reject, 1'b1);
      check(seen_q[1], CLS_B);
      check(8'(n_rst), 8'h02);
      check(atr_sent, 1'b0);
      activate(3'h6, 5'h06, 1'b0, 1'b1);
      check(reject, 1'b1);
      check(cnt, 2'h3);
      check(8'(n_rst), 8'h06);
      check(8'(seen_q.size()), 8'h02);
      check(seen_q[1], CLS_B);
      activate(3'h7, 5'h05, 1'b0, 1'b0);
      check(ind_ok, 1'b0);
      check(ready, 1'b1);
      check(cnt, 2'h0);
      activate(CLS_NONE, 5'h06, 1'b0, 1'b0);
      check(reject, 1'b1);
      check(ready, 1'b0);
      give_verdict();
   end
endmodule
